// *** design/acs_pkg.sv ***
/*
 * package for the conversion sequencer: register layout, defaults,
 * input selector codes, timing constants, carrier structs.
 * assumes a 100 mhz clk; nothing else.
 */
package acs_pkg;

    localparam int unsigned CLK_MHZ            = 100;
    localparam int unsigned PWRUP_RESET_US     = 50;
    localparam int unsigned PWRUP_RESET_CYCLES = PWRUP_RESET_US * CLK_MHZ;
    localparam int unsigned CONV_CYCLES_DEF    = 4144;

    // register indices on the plain port
    localparam logic [3:0] ADDR_CFG0   = 4'h0;
    localparam logic [3:0] ADDR_CFG1   = 4'h1;
    localparam logic [3:0] ADDR_CMD    = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_DATA   = 4'h4;

    // cfg0 fields
    localparam int unsigned CFG0_BURNOUT_BIT = 0;
    localparam int unsigned CFG0_BYPASS_BIT  = 1;
    localparam int unsigned CFG0_GAIN_LSB    = 2;
    localparam int unsigned CFG0_SEL_LSB     = 4;
    // cfg1 fields
    localparam int unsigned CFG1_TEMP_BIT    = 0;
    localparam int unsigned CFG1_CONT_BIT    = 1;
    localparam int unsigned CFG1_SWITCH_BIT  = 2;
    localparam int unsigned CFG1_VREF_LSB    = 3;
    // cmd bits
    localparam int unsigned CMD_START_BIT    = 0;
    localparam int unsigned CMD_SLEEP_BIT    = 1;

    localparam logic [7:0] CFG0_DEFAULT = 8'h00;
    localparam logic [7:0] CFG1_DEFAULT = 8'h00;

    localparam logic [3:0] SEL_REF_MON    = 4'hc;
    localparam logic [3:0] SEL_SUPPLY_MON = 4'hd;
    localparam logic [1:0] VREF_INTERNAL  = 2'h0;
    localparam logic [2:0] GAIN_ONE       = 3'h0;
    localparam int unsigned TEMP_BITS     = 14;
    localparam int unsigned RESULT_BITS   = 24;

    typedef enum logic [1:0] {
        ST_RESET, ST_CONVERT, ST_IDLE, ST_SLEEP
    } acs_state_t;

    // analog control bundle driven to the front end
    typedef struct packed {
        logic       gain_amplifier_bypass;
        logic [2:0] gain_code;
        logic [1:0] vref_sel;
        logic [3:0] input_selector;
        logic       burnout_source_enable;
        logic       temp_sensor_on;
        logic       analog_on;
        logic       bridge_switch_closed;
    } acs_analog_t;

    typedef struct packed {
        acs_state_t        state;
        logic [7:0]        cfg0;
        logic [7:0]        cfg1;
        logic [15:0]       pwr_cnt;
        logic [23:0]       conv_cnt;
        logic              sleep_pending;
        logic              temp_conv;
        logic              switch_closed;
        logic [23:0]       result;
        logic              ready_n;
        logic [23:0]       rdata;
    } acs_state_vec_t;

endpackage : acs_pkg

// *** design/acs_sequencer.sv ***
/*
 * conversion sequencer: power-up reset, single-shot and continuous
 * conversion, restart on configuration write, bridge switch, burn-out
 * sources, system monitor override, temperature formatting.
 * assumes a modulator that hands back a raw result when conv_done is
 * signalled by this block's own counter, and a host on the plain port.
 */
// Behaviour
// - switch closes on start, opens on sleep
// - single-shot keeps switch closed between conversions
// - enable cleared opens switch; open after reset
// - burn-out enable drives the two burn-out sources
// - monitor codes force bypass and gain one
// - code 1101 measures supply over internal ref
// - code 1100 measures reference over internal ref
// - temperature mode ignores cfg0, internal ref
// - temperature result 14 bits left-justified
// - temperature result is two's complement
// - about 50 us power-up reset first
// - reset loads defaults, single-shot default
// - power-up conversion, then low power, ready low
// - one bit selects single-shot or continuous
// - single-shot converts once per start
// - single-shot idle stops oscillator and analog
// - single-shot config write starts a conversion
// - config write mid-conversion restarts conversion
// - every result is settled, none discarded
// - continuous stores result, restarts at once
// - sleep finishes conversion, keeps config, responsive
// - ready low on new data, high on read
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer #(
    parameter int unsigned PWRUP_CYCLES = acs_pkg::PWRUP_RESET_CYCLES,
    parameter int unsigned CONV_CYCLES  = acs_pkg::CONV_CYCLES_DEF
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [3:0]         addr,
    input  wire logic [7:0]         wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic      [23:0]        rdata,
    input  wire logic [23:0]        raw_result,
    input  wire logic               data_read,
    output logic                    result_ready_n,
    output logic                    host_ready,
    output logic                    conversion_active,
    output acs_pkg::acs_analog_t    analog
);

    acs_pkg::acs_state_vec_t s_reg;
    acs_pkg::acs_state_vec_t s_next;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_monitor(input logic [3:0] sel);
        is_monitor = (sel == acs_pkg::SEL_REF_MON) ||
                     (sel == acs_pkg::SEL_SUPPLY_MON);
    endfunction : is_monitor

    // left-justify the 14-bit two's complement code; top bit is sign
    function automatic logic [23:0] temp_format(input logic [23:0] raw);
        temp_format = {raw[13:0], 10'h000};
    endfunction : temp_format

    logic cfg_wr;
    logic start_cmd;
    logic sleep_cmd;
    logic conv_done;
    logic cont_mode;
    logic sw_en;
    logic sw_now;

    always_comb begin
        cfg_wr    = wr && (addr == acs_pkg::ADDR_CFG0 ||
                           addr == acs_pkg::ADDR_CFG1);
        start_cmd = wr && addr == acs_pkg::ADDR_CMD &&
                    wdata[acs_pkg::CMD_START_BIT];
        sleep_cmd = wr && addr == acs_pkg::ADDR_CMD &&
                    wdata[acs_pkg::CMD_SLEEP_BIT];
        conv_done = s_reg.state == acs_pkg::ST_CONVERT &&
                    s_reg.conv_cnt == 24'(CONV_CYCLES - 1);
        cont_mode = s_reg.cfg1[acs_pkg::CFG1_CONT_BIT];
        sw_en     = s_reg.cfg1[acs_pkg::CFG1_SWITCH_BIT];
        // switch enable as it will stand after this cycle's write
        sw_now    = (wr && addr == acs_pkg::ADDR_CFG1) ?
                    wdata[acs_pkg::CFG1_SWITCH_BIT] : sw_en;
    end

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 24'h000000;
        if (s_reg.state != acs_pkg::ST_CONVERT) begin
            s_next.conv_cnt = 24'h000000;
        end else begin
            s_next.conv_cnt = s_reg.conv_cnt + 24'h000001;
        end
        if (s_reg.state != acs_pkg::ST_RESET) begin
            if (wr && addr == acs_pkg::ADDR_CFG0) begin
                s_next.cfg0 = wdata;
            end
            if (wr && addr == acs_pkg::ADDR_CFG1) begin
                s_next.cfg1 = wdata;
            end
        end
        // host read clears the ready flag; completion below wins
        if (data_read || (rd && addr == acs_pkg::ADDR_DATA)) begin
            s_next.ready_n = 1'b1;
        end
        case (s_reg.state)
            acs_pkg::ST_RESET: begin
                s_next.pwr_cnt = s_reg.pwr_cnt + 16'h0001;
                if (s_reg.pwr_cnt == 16'(PWRUP_CYCLES - 1)) begin
                    s_next.state     = acs_pkg::ST_CONVERT;
                    s_next.temp_conv =
                        s_reg.cfg1[acs_pkg::CFG1_TEMP_BIT];
                end
            end
            acs_pkg::ST_CONVERT: begin
                if (sleep_cmd) begin
                    s_next.sleep_pending = 1'b1;
                end
                if (conv_done) begin
                    // single-cycle settling filter: keep every result
                    s_next.result = s_reg.temp_conv ?
                        temp_format(raw_result) : raw_result;
                    s_next.ready_n  = 1'b0;
                    s_next.conv_cnt = 24'h000000;
                    if (s_reg.sleep_pending || sleep_cmd) begin
                        s_next.state         = acs_pkg::ST_SLEEP;
                        s_next.sleep_pending = 1'b0;
                        s_next.switch_closed = 1'b0;
                    end else if (cont_mode) begin
                        s_next.state = acs_pkg::ST_CONVERT;
                    end else begin
                        s_next.state = acs_pkg::ST_IDLE;
                    end
                end
                if (cfg_wr) begin
                    s_next.state     = acs_pkg::ST_CONVERT;
                    s_next.conv_cnt  = 24'h000000;
                    s_next.cfg1      = (addr == acs_pkg::ADDR_CFG1) ?
                                       wdata : s_reg.cfg1;
                end
                if (start_cmd && !conv_done) begin
                    s_next.conv_cnt = 24'h000000;
                end
            end
            acs_pkg::ST_IDLE, acs_pkg::ST_SLEEP: begin
                if (start_cmd || cfg_wr) begin
                    s_next.state = acs_pkg::ST_CONVERT;
                end
                if (sleep_cmd && !start_cmd && !cfg_wr) begin
                    s_next.state         = acs_pkg::ST_SLEEP;
                    s_next.switch_closed = 1'b0;
                end
            end
            default: begin
                s_next.state = acs_pkg::ST_RESET;
            end
        endcase
        // latch temperature mode at every conversion start
        if (s_next.state == acs_pkg::ST_CONVERT &&
            (s_reg.state != acs_pkg::ST_CONVERT || cfg_wr ||
             conv_done)) begin
            s_next.temp_conv = (wr && addr == acs_pkg::ADDR_CFG1) ?
                wdata[acs_pkg::CFG1_TEMP_BIT] :
                s_reg.cfg1[acs_pkg::CFG1_TEMP_BIT];
        end
        // a config write starts a conversion just as start does
        if ((start_cmd || (cfg_wr && s_reg.state != acs_pkg::ST_RESET)) &&
            sw_now) begin
            s_next.switch_closed = 1'b1;
        end
        if (wr && addr == acs_pkg::ADDR_CFG1 &&
            !wdata[acs_pkg::CFG1_SWITCH_BIT]) begin
            s_next.switch_closed = 1'b0;
        end
        if (rd) begin
            case (addr)
                acs_pkg::ADDR_CFG0:   s_next.rdata = {16'h0000, s_reg.cfg0};
                acs_pkg::ADDR_CFG1:   s_next.rdata = {16'h0000, s_reg.cfg1};
                acs_pkg::ADDR_STATUS: s_next.rdata =
                    {21'h000000, s_reg.ready_n, s_reg.state};
                acs_pkg::ADDR_DATA:   s_next.rdata = s_reg.result;
                default:              s_next.rdata = 24'h000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_reg.state         <= acs_pkg::ST_RESET;
            s_reg.cfg0          <= acs_pkg::CFG0_DEFAULT;
            s_reg.cfg1          <= acs_pkg::CFG1_DEFAULT;
            s_reg.pwr_cnt       <= 16'h0000;
            s_reg.conv_cnt      <= 24'h000000;
            s_reg.sleep_pending <= 1'b0;
            s_reg.temp_conv     <= 1'b0;
            s_reg.switch_closed <= 1'b0;
            s_reg.result        <= 24'h000000;
            s_reg.ready_n       <= 1'b1;
            s_reg.rdata         <= 24'h000000;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    logic       temp_on;
    logic       mon_on;
    logic [3:0] sel;

    always_comb begin
        temp_on = s_reg.cfg1[acs_pkg::CFG1_TEMP_BIT];
        sel     = s_reg.cfg0[acs_pkg::CFG0_SEL_LSB +: 4];
        mon_on  = !temp_on && is_monitor(sel);
        // temperature mode ignores the whole first register
        analog.input_selector        = temp_on ? 4'h0 : sel;
        analog.burnout_source_enable = !temp_on &&
            s_reg.cfg0[acs_pkg::CFG0_BURNOUT_BIT];
        analog.gain_amplifier_bypass = temp_on ? 1'b0 :
            (mon_on || s_reg.cfg0[acs_pkg::CFG0_BYPASS_BIT]);
        analog.gain_code = (temp_on || mon_on) ? acs_pkg::GAIN_ONE :
            s_reg.cfg0[acs_pkg::CFG0_GAIN_LSB +: 3];
        // both monitor codes and temperature use the internal ref
        analog.vref_sel = (temp_on || mon_on) ? acs_pkg::VREF_INTERNAL :
            s_reg.cfg1[acs_pkg::CFG1_VREF_LSB +: 2];
        analog.temp_sensor_on = temp_on;
        // oscillator and analog off outside conversions
        analog.analog_on = s_reg.state == acs_pkg::ST_CONVERT;
        analog.bridge_switch_closed = s_reg.switch_closed && sw_en;
        result_ready_n    = s_reg.ready_n;
        host_ready        = s_reg.state != acs_pkg::ST_RESET;
        conversion_active = s_reg.state == acs_pkg::ST_CONVERT;
        rdata             = s_reg.rdata;
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    property p_switch_close;
        @(posedge clk) disable iff (rst)
        (start_cmd && sw_en && !(wr && addr == acs_pkg::ADDR_CFG1))
            |=> analog.bridge_switch_closed;
    endproperty
    a_switch_close: assert property (p_switch_close)
        else $error("switch not closed after start");

    property p_switch_open;
        @(posedge clk) disable iff (rst)
        (wr && addr == acs_pkg::ADDR_CFG1 &&
         !wdata[acs_pkg::CFG1_SWITCH_BIT]) |=> !analog.bridge_switch_closed;
    endproperty
    a_switch_open: assert property (p_switch_open)
        else $error("switch not opened by enable clear");

    property p_idle_switch;
        @(posedge clk) disable iff (rst)
        (s_reg.state == acs_pkg::ST_IDLE && $past(s_reg.state) ==
         acs_pkg::ST_IDLE && $past(analog.bridge_switch_closed) && sw_en &&
         !sleep_cmd) |-> analog.bridge_switch_closed;
    endproperty
    a_idle_switch: assert property (p_idle_switch)
        else $error("switch dropped while idle");

    property p_monitor_gain;
        @(posedge clk) disable iff (rst)
        mon_on |-> (analog.gain_code == acs_pkg::GAIN_ONE &&
                    analog.gain_amplifier_bypass &&
                    analog.vref_sel == acs_pkg::VREF_INTERNAL);
    endproperty
    a_monitor_gain: assert property (p_monitor_gain)
        else $error("monitor override missing");

    property p_done_ready;
        @(posedge clk) disable iff (rst)
        (conv_done && !cfg_wr && !data_read && !rd) |=> !result_ready_n;
    endproperty
    a_done_ready: assert property (p_done_ready)
        else $error("ready not asserted on completion");

    property p_cfg_restart;
        @(posedge clk) disable iff (rst)
        (cfg_wr && s_reg.state != acs_pkg::ST_RESET) |=>
            (conversion_active && s_reg.conv_cnt == 24'h000000);
    endproperty
    a_cfg_restart: assert property (p_cfg_restart)
        else $error("config write did not restart");

    property p_single_idle;
        @(posedge clk) disable iff (rst)
        (conv_done && !cont_mode && !cfg_wr && !sleep_cmd &&
         !s_reg.sleep_pending) |=> (s_reg.state == acs_pkg::ST_IDLE &&
                                    !analog.analog_on);
    endproperty
    a_single_idle: assert property (p_single_idle)
        else $error("single-shot did not stop");

    property p_cont_next;
        @(posedge clk) disable iff (rst)
        (conv_done && cont_mode && !sleep_cmd && !s_reg.sleep_pending)
            |=> conversion_active;
    endproperty
    a_cont_next: assert property (p_cont_next)
        else $error("continuous mode stopped");

    property p_read_clear;
        @(posedge clk) disable iff (rst)
        (data_read && !conv_done) |=> result_ready_n;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("ready not released by read");

    property p_powerup_hold;
        @(posedge clk) disable iff (rst)
        (s_reg.state == acs_pkg::ST_RESET &&
         s_reg.pwr_cnt != 16'(PWRUP_CYCLES - 1)) |=> !host_ready;
    endproperty
    a_powerup_hold: assert property (p_powerup_hold)
        else $error("host port opened before power-up count");

    property p_powerup_conv;
        @(posedge clk) disable iff (rst)
        (s_reg.state == acs_pkg::ST_RESET &&
         s_reg.pwr_cnt == 16'(PWRUP_CYCLES - 1)) |=> conversion_active;
    endproperty
    a_powerup_conv: assert property (p_powerup_conv)
        else $error("no conversion after power-up");

    property p_temp_word;
        @(posedge clk) disable iff (rst)
        (conv_done && s_reg.temp_conv) |=>
            (s_reg.result == ($past(raw_result) << 10));
    endproperty
    a_temp_word: assert property (p_temp_word)
        else $error("temperature word not left-justified");

    property p_raw_word;
        @(posedge clk) disable iff (rst)
        (conv_done && !s_reg.temp_conv) |=>
            (s_reg.result == $past(raw_result));
    endproperty
    a_raw_word: assert property (p_raw_word)
        else $error("finished result not stored");

    property p_sleep_finish;
        @(posedge clk) disable iff (rst)
        (conversion_active && sleep_cmd && !conv_done) |=>
            (conversion_active && s_reg.sleep_pending);
    endproperty
    a_sleep_finish: assert property (p_sleep_finish)
        else $error("sleep cut the conversion short");

    property p_temp_ignore;
        @(posedge clk) disable iff (rst)
        analog.temp_sensor_on |-> (!analog.burnout_source_enable &&
            analog.input_selector == 4'h0 &&
            analog.vref_sel == acs_pkg::VREF_INTERNAL);
    endproperty
    a_temp_ignore: assert property (p_temp_ignore)
        else $error("temperature mode used first register");

    property p_data_read_clear;
        @(posedge clk) disable iff (rst)
        (rd && addr == acs_pkg::ADDR_DATA && !conv_done) |=> result_ready_n;
    endproperty
    a_data_read_clear: assert property (p_data_read_clear)
        else $error("ready not released by data read");

endmodule : acs_sequencer
`default_nettype wire

// *** sim/acs_host_model.sv ***
/*
 * host model: plain-port bus master plus the serial read edge.
 * assumes one clk shared with the sequencer, no reset of its own.
 */
`timescale 1ns/10ps
`default_nettype none
module acs_host_model (
    input  wire logic        clk,
    input  wire logic        host_ready,
    input  wire logic [23:0] rdata,
    output var  logic [3:0]  addr,
    output var  logic [7:0]  wdata,
    output var  logic        wr,
    output var  logic        rd,
    output var  logic        data_read
);
    initial begin
        addr      = 4'h0;
        wdata     = 8'h00;
        wr        = 1'b0;
        rd        = 1'b0;
        data_read = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // writes before the power-up count ends would be dropped silently
    task automatic write(input logic [3:0] a, input logic [7:0] d);
        while (host_ready !== 1'b1) @(posedge clk);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
    endtask : write

    // rdata stands one cycle only, so it is taken just after the edge
    task automatic read(input logic [3:0] a, output logic [23:0] q);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 q = rdata;
    endtask : read

    task automatic serial_edge();
        @(posedge clk);
        data_read <= 1'b1;
        @(posedge clk);
        data_read <= 1'b0;
    endtask : serial_edge
endmodule : acs_host_model
`default_nettype wire

// *** sim/tb_top.sv ***
/*
 * self-checking bench for the conversion sequencer.
 * assumes the host model is compiled first; counts are shortened.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int         PW    = 20;
    localparam int         CV    = 16;
    localparam logic [7:0] SW    = 8'h01 << acs_pkg::CFG1_SWITCH_BIT;
    localparam logic [7:0] CONT  = 8'h01 << acs_pkg::CFG1_CONT_BIT;
    localparam logic [7:0] TEMP  = 8'h01 << acs_pkg::CFG1_TEMP_BIT;
    localparam logic [7:0] VR    = 8'h02 << acs_pkg::CFG1_VREF_LSB;
    localparam logic [7:0] START = 8'h01 << acs_pkg::CMD_START_BIT;
    localparam logic [7:0] SLEEP = 8'h01 << acs_pkg::CMD_SLEEP_BIT;
    logic                 clk = 1'b0;
    logic                 rst;
    logic [3:0]           addr;
    logic [7:0]           wdata;
    logic                 wr;
    logic                 rd;
    logic [23:0]          rdata;
    logic [23:0]          raw_result;
    logic                 data_read;
    logic                 result_ready_n;
    logic                 host_ready;
    logic                 conversion_active;
    acs_pkg::acs_analog_t analog;
    int                   checks = 0;
    int                   mismatches = 0;
    int                   cycles = 0;
    int                   n;
    logic [23:0]          q;
    logic [7:0]           d;
    logic [2:0]           g;
    logic [1:0]           v;
    logic [13:0]          t;
    logic [13:0]          tv [3] = '{14'h3b00, 14'h0fff, 14'h2000};

    acs_sequencer #(.PWRUP_CYCLES(PW), .CONV_CYCLES(CV)) uut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .raw_result(raw_result),
        .data_read(data_read), .result_ready_n(result_ready_n),
        .host_ready(host_ready), .conversion_active(conversion_active),
        .analog(analog));
    acs_host_model host (
        .clk(clk), .host_ready(host_ready), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .data_read(data_read));

    always #5 clk = ~clk;
    // the whole run needs about 410 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////
    function automatic logic mon(input logic [3:0] s);
        return s == acs_pkg::SEL_REF_MON || s == acs_pkg::SEL_SUPPLY_MON;
    endfunction : mon

    function automatic logic [23:0] temp_word(input logic [13:0] r);
        return {r, 10'h000};
    endfunction : temp_word

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk_val

    task automatic chk_flag(input logic got, input logic exp);
        chk_val({23'h0, got}, {23'h0, exp});
    endtask : chk_flag

    // bounded wait until ready stands low (at once if already low); n counts the cycles
    task automatic wait_done(output int c);
        c = 0;
        while (result_ready_n !== 1'b0 && c < 200) begin
            @(posedge clk);
            #1 c++;
        end
        chk_flag(result_ready_n, 1'b0);
    endtask : wait_done

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h4c3bc8d0));
        rst        = 1'b1;
        raw_result = 24'($urandom);
        #1 chk_flag(result_ready_n, 1'b1);
        chk_flag(analog.bridge_switch_closed, 1'b0);
        chk_flag(host_ready, 1'b0);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        n = 0;
        while (host_ready !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        chk_flag(n >= PW - 1 && n <= PW + 2, 1'b1);
        chk_flag(conversion_active, 1'b1);
        wait_done(n);
        chk_flag(n <= CV + 2, 1'b1);
        chk_flag(conversion_active, 1'b0);
        chk_flag(analog.analog_on, 1'b0);
        host.read(acs_pkg::ADDR_CFG0, q);
        chk_val(q, 24'(acs_pkg::CFG0_DEFAULT));
        host.read(acs_pkg::ADDR_CFG1, q);
        chk_val(q, 24'(acs_pkg::CFG1_DEFAULT));
        host.read(4'h7, q);
        chk_val(q, 24'h0);
        host.serial_edge();
        #1 chk_flag(result_ready_n, 1'b1);
        $display("test powerup done");
        host.write(acs_pkg::ADDR_CFG1, SW);
        #1 chk_flag(conversion_active, 1'b1);
        chk_flag(analog.bridge_switch_closed, 1'b1);
        wait_done(n);
        chk_flag(analog.bridge_switch_closed, 1'b1);
        host.serial_edge();
        host.write(acs_pkg::ADDR_CMD, START);
        host.write(acs_pkg::ADDR_CMD, SLEEP);
        #1 chk_flag(conversion_active, 1'b1);
        wait_done(n);
        chk_flag(analog.bridge_switch_closed, 1'b0);
        host.read(acs_pkg::ADDR_STATUS, q);
        chk_val(24'(q[1:0]), 24'(acs_pkg::ST_SLEEP));
        host.read(acs_pkg::ADDR_CFG1, q);
        chk_val(q, 24'(SW));
        host.serial_edge();
        host.write(acs_pkg::ADDR_CMD, START);
        #1 chk_flag(analog.bridge_switch_closed, 1'b1);
        repeat (8) @(posedge clk);
        host.write(acs_pkg::ADDR_CFG1, 8'h00);
        #1 chk_flag(analog.bridge_switch_closed, 1'b0);
        wait_done(n);
        chk_flag(n >= CV - 2, 1'b1);
        host.serial_edge();
        $display("test switch done");
        host.write(acs_pkg::ADDR_CFG1, CONT);
        host.write(acs_pkg::ADDR_CMD, START);
        @(posedge clk);
        raw_result <= 24'($urandom);
        wait_done(n);
        host.read(acs_pkg::ADDR_DATA, q);
        chk_val(q, raw_result);
        chk_flag(conversion_active, 1'b1);
        @(posedge clk);
        raw_result <= ~raw_result;
        wait_done(n);
        chk_flag(n <= CV + 2, 1'b1);
        host.read(acs_pkg::ADDR_DATA, q);
        chk_val(q, raw_result);
        host.write(acs_pkg::ADDR_CFG1, VR);
        wait_done(n);
        host.serial_edge();
        $display("test continuous done");
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            if (i < 2) begin
                d[7:4] = (i == 1) ? acs_pkg::SEL_SUPPLY_MON :
                                    acs_pkg::SEL_REF_MON;
            end
            g = mon(d[7:4]) ? acs_pkg::GAIN_ONE : d[4:2];
            v = mon(d[7:4]) ? acs_pkg::VREF_INTERNAL : VR[4:3];
            host.write(acs_pkg::ADDR_CFG0, d);
            #1 chk_flag(analog.burnout_source_enable, d[0]);
            chk_flag(analog.gain_amplifier_bypass, mon(d[7:4]) | d[1]);
            chk_val(24'(analog.gain_code), 24'(g));
            chk_val(24'(analog.vref_sel), 24'(v));
            chk_val(24'(analog.input_selector), 24'(d[7:4]));
            wait_done(n);
            host.serial_edge();
        end
        $display("test monitor done");
        host.write(acs_pkg::ADDR_CFG0, 8'hd1);
        wait_done(n);
        host.serial_edge();
        for (int i = 0; i < 4; i++) begin
            t = (i < 3) ? tv[i] : 14'($urandom);
            @(posedge clk);
            raw_result <= {10'($urandom), t};
            host.write(acs_pkg::ADDR_CFG1, TEMP | VR);
            #1 chk_flag(analog.burnout_source_enable, 1'b0);
            chk_val(24'(analog.vref_sel), 24'(acs_pkg::VREF_INTERNAL));
            chk_val(24'(analog.input_selector), 24'h0);
            chk_flag(analog.temp_sensor_on, 1'b1);
            wait_done(n);
            host.read(acs_pkg::ADDR_DATA, q);
            chk_val(q, temp_word(t));
        end
        $display("test temperature done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
